/* File: fsc_defines.svh */
// Offsets, field positions and reset values of the framer control registers
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define FSC_IDX_SIG_CTRL   6'h11
`define FSC_IDX_TX_CRC_MON 6'h19
`define FSC_IDX_RX_CRC_MON 6'h1e
`define FSC_IDX_TX_MON_REG 6'h3f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FSC_BIT_REINSERT    7
`define FSC_BIT_RX_PER_CH   6
`define FSC_BIT_FORCE_ONES  5
`define FSC_BIT_FREEZE_EN   4
`define FSC_BIT_FORCE_FRZ   3
`define FSC_BIT_TX_HW_INS   2
`define FSC_BIT_TX_PER_CH   1
`define FSC_BIT_IDLE_FSEL   0
`define FSC_BIT_JAPAN_CRC   7
`define FSC_MON_SEL_MSB     4
`define FSC_MON_SEL_LSB     0
`define FSC_TX_CRC_WMASK    8'h9f

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define FSC_RST_SIG_CTRL    8'h00
`define FSC_RST_TX_CRC_MON  8'h00
`define FSC_RST_RX_CRC_MON  8'h00
`define FSC_RST_MON_DATA    8'h00
`define FSC_RESP_OKAY       2'h0
`define FSC_RESP_SLVERR     2'h2

`endif

/* File: fsc_pkg.sv */
// Types shared by the framer signaling and CRC control registers
package fsc_pkg;

  // Signaling control register layout
  typedef struct packed {
    logic reinsert_en;
    logic rx_per_ch;
    logic force_ones;
    logic freeze_en;
    logic force_freeze;
    logic tx_hw_ins;
    logic tx_per_ch;
    logic idle_fsel;
  } fsc_sig_ctrl_s;

  // Transmit CRC and monitor select layout
  typedef struct packed {
    logic       japan_crc;
    logic [1:0] unused;
    logic [4:0] mon_sel;
  } fsc_tx_crc_s;

  // Control levels handed to the framer datapath
  typedef struct packed {
    logic rx_sig_freeze;
    logic rx_ser_freeze;
    logic rx_force_ones;
    logic rx_reinsert;
    logic tx_japan_crc;
    logic rx_japan_crc;
  } fsc_ctrl_out_s;

endpackage

/* File: fsc_chan_sel.sv */
// Channel monitor capture: copies the selected channel's byte
`timescale 1ns/1ps
`include "fsc_defines.svh"

module fsc_chan_sel #(
  parameter int NUM_CHANNELS = 24
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // Channel selection
  input  wire logic [4:0] sel,
  // Transmit channel stream
  input  wire logic [4:0] chan_num,
  input  wire logic       chan_valid,
  input  wire logic [7:0] chan_data,
  // Captured byte
  output logic      [7:0] mon_data
);
  generate
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 32) begin : g_chk
      $error("fsc_chan_sel: channel count out of range");
    end
  endgenerate

  // Capture on a match; a select past the last channel never matches
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mon_data <= `FSC_RST_MON_DATA;
    end else if (chan_valid && chan_num == sel) begin
      mon_data <= chan_data;
    end
  end
endmodule // fsc_chan_sel

/* File: fsc_regs.sv */
// Framer signaling control and CRC/monitor select register bank
`timescale 1ns/1ps
`include "fsc_defines.svh"

// Overview of operation
// - Registers at indices 11h, 19h, 1Eh; byte address is index times four.
// - Freeze enable lets a freeze request freeze signaling, and data if reinserting.
// - Force freeze freezes signaling output regardless of freeze enable.
// - Hardware insert bit inserts signaling pin values into transmit data.
// - Per-channel bit makes channel-block input choose inserted channels.
// - Idle function select zero: idle flags mark idle code channels.
// - Idle function select one: idle flags mark per-channel loopback.
// - Transmit CRC select: zero normal CRC6, one Japanese CRC6.
// - Five-bit field picks the transmit channel copied to monitor register.
module fsc_regs
  import fsc_pkg::*;
#(
  parameter int NUM_CHANNELS = 24
) (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  // Avalon-MM slave
  input  wire logic [7:0]              address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  output logic      [31:0]             readdata,
  output logic      [1:0]              response,
  output logic                         waitrequest,
  // Receive side pins and events
  input  wire logic                    rx_freeze_req,
  input  wire logic                    rx_channel_block,
  // Transmit side pins and idle flags
  input  wire logic                    tx_channel_block_in,
  input  wire logic                    tx_idle_flag,
  // Transmit channel stream for the monitor
  input  wire logic [4:0]              tx_chan_num,
  input  wire logic                    tx_chan_valid,
  input  wire logic [7:0]              tx_chan_data,
  // Datapath controls
  output fsc_pkg::fsc_ctrl_out_s       ctrl,
  output logic                         rx_reinsert_now,
  output logic                         tx_sig_insert_now,
  output logic                         tx_idle_code_now,
  output logic                         tx_loopback_now,
  output logic      [4:0]              rx_monitor_channel_sel,
  output logic                         rx_elastic_align,
  output logic                         tx_elastic_align
);
  import fsc_pkg::*;

  generate
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 32) begin : g_chk
      $error("fsc_regs: channel count out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  fsc_sig_ctrl_s signaling_control;
  fsc_tx_crc_s   tx_crc_and_monitor_select;
  logic [7:0]    rx_crc_align_monitor_select;
  logic [7:0]    tx_channel_monitor_reg;

  // Address match on a word-aligned register index
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, `FSC_IDX_SIG_CTRL) || hit(a, `FSC_IDX_TX_CRC_MON) ||
             hit(a, `FSC_IDX_RX_CRC_MON) || hit(a, `FSC_IDX_TX_MON_REG);
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_do;
  assign bus_req = read || write;
  // Accept edge: the cycle in which waitrequest is already low
  assign bus_do  = bus_req && !waitrequest;

  // One wait cycle per access, then release for one cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !(bus_req && waitrequest);
    end
  end

  // Read data and status prepared during the wait cycle
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
      response <= `FSC_RESP_OKAY;
    end else if (bus_req && waitrequest) begin
      response <= mapped(address) ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
      if (!read) begin
        readdata <= 32'h0000_0000;
      end else if (hit(address, `FSC_IDX_SIG_CTRL)) begin
        readdata <= {24'h00_0000, signaling_control};
      end else if (hit(address, `FSC_IDX_TX_CRC_MON)) begin
        readdata <= {24'h00_0000, tx_crc_and_monitor_select};
      end else if (hit(address, `FSC_IDX_RX_CRC_MON)) begin
        readdata <= {24'h00_0000, rx_crc_align_monitor_select};
      end else if (hit(address, `FSC_IDX_TX_MON_REG)) begin
        readdata <= {24'h00_0000, tx_channel_monitor_reg};
      end else begin
        readdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // signaling control write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      signaling_control <= `FSC_RST_SIG_CTRL;
    end else if (bus_do && write && hit(address, `FSC_IDX_SIG_CTRL)) begin
      signaling_control <= writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_crc_and_monitor_select <= `FSC_RST_TX_CRC_MON;
    end else if (bus_do && write && hit(address, `FSC_IDX_TX_CRC_MON)) begin
      tx_crc_and_monitor_select <= writedata[7:0] & `FSC_TX_CRC_WMASK;
    end
  end

  // receive CRC, align and monitor write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_crc_align_monitor_select <= `FSC_RST_RX_CRC_MON;
    end else if (bus_do && write && hit(address, `FSC_IDX_RX_CRC_MON)) begin
      rx_crc_align_monitor_select <= writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;

  // Two stages; only the second stage feeds the control logic
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {rx_freeze_req, rx_channel_block, tx_channel_block_in};
      pin_sync <= pin_meta;
    end
  end

  logic freeze_req_s;
  logic rx_blk_s;
  logic tx_blk_s;
  assign freeze_req_s = pin_sync[2];
  assign rx_blk_s     = pin_sync[1];
  assign tx_blk_s     = pin_sync[0];

  // ----------------------------------------------------------------
  // Receive signaling controls
  // ----------------------------------------------------------------
  logic next_freeze;
  logic rx_sig_freeze, rx_ser_freeze, rx_force_ones;
  logic rx_reinsert, tx_japan_crc, rx_japan_crc;
  assign next_freeze = signaling_control.force_freeze ||
                       (signaling_control.freeze_en && freeze_req_s);

  // Freeze also covers receive data only while reinsertion is on
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_sig_freeze <= 1'b0;
      rx_ser_freeze <= 1'b0;
    end else begin
      rx_sig_freeze <= next_freeze;
      rx_ser_freeze <= next_freeze && signaling_control.reinsert_en;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_force_ones   <= 1'b0;
      rx_reinsert     <= 1'b0;
      rx_reinsert_now <= 1'b0;
    end else begin
      rx_force_ones   <= signaling_control.force_ones;
      rx_reinsert     <= signaling_control.reinsert_en;
      rx_reinsert_now <= signaling_control.reinsert_en &&
                         (!signaling_control.rx_per_ch || rx_blk_s);
    end
  end

  // ----------------------------------------------------------------
  // Transmit signaling and idle channel controls
  // ----------------------------------------------------------------
  // hardware insertion
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_sig_insert_now <= 1'b0;
    end else begin
      tx_sig_insert_now <= signaling_control.tx_hw_ins &&
                           (!signaling_control.tx_per_ch || tx_blk_s);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_idle_code_now <= 1'b0;
      tx_loopback_now  <= 1'b0;
    end else begin
      tx_idle_code_now <= tx_idle_flag && !signaling_control.idle_fsel;
      tx_loopback_now  <= tx_idle_flag && signaling_control.idle_fsel;
    end
  end

  // ----------------------------------------------------------------
  // CRC selection, alignment and monitor
  // ----------------------------------------------------------------
  // CRC methods, receive monitor select and elastic alignment
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_japan_crc           <= 1'b0;
      rx_japan_crc           <= 1'b0;
      rx_monitor_channel_sel <= 5'h00;
      rx_elastic_align       <= 1'b0;
      tx_elastic_align       <= 1'b0;
    end else begin
      tx_japan_crc           <= tx_crc_and_monitor_select.japan_crc;
      rx_japan_crc           <= rx_crc_align_monitor_select[7];
      rx_monitor_channel_sel <= rx_crc_align_monitor_select[4:0];
      rx_elastic_align       <= rx_crc_align_monitor_select[6];
      tx_elastic_align       <= rx_crc_align_monitor_select[5];
    end
  end

  // One driver for the whole struct; fields come from separate flops
  assign ctrl = {rx_sig_freeze, rx_ser_freeze, rx_force_ones,
                 rx_reinsert, tx_japan_crc, rx_japan_crc};

  fsc_chan_sel #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_mon (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .sel        (tx_crc_and_monitor_select.mon_sel),
    .chan_num   (tx_chan_num),
    .chan_valid (tx_chan_valid),
    .chan_data  (tx_chan_data),
    .mon_data   (tx_channel_monitor_reg)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_wait;
    bus_req && waitrequest;
  endsequence
  sequence s_accept;
    bus_req && !waitrequest;
  endsequence
  sequence s_wr_sig;
    s_accept ##0 (write && hit(address, `FSC_IDX_SIG_CTRL));
  endsequence
  AST_BUS_ONE_WAIT:
    assert property (s_wait ##1 bus_req |-> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");
  AST_SIG_WRITE:
    assert property (s_wr_sig |=> signaling_control == $past(writedata[7:0]))
    else $error("signaling control write not stored");
  AST_TX_CRC_MASK:
    assert property (tx_crc_and_monitor_select.unused == 2'b00)
    else $error("unassigned transmit CRC bits not zero");
  AST_FREEZE:
    assert property (signaling_control.freeze_en && freeze_req_s &&
                     $stable(signaling_control) |=>
                     ctrl.rx_sig_freeze &&
                     ctrl.rx_ser_freeze ==
                     $past(signaling_control.reinsert_en))
    else $error("enabled freeze request did not freeze");
  AST_FORCE_FREEZE:
    assert property ($past(signaling_control.force_freeze) |->
                     ctrl.rx_sig_freeze)
    else $error("forced freeze not applied");
  AST_NO_FREEZE:
    assert property (!signaling_control.force_freeze &&
                     !signaling_control.freeze_en |=> !ctrl.rx_sig_freeze)
    else $error("freeze without enable or force");
  AST_TX_INSERT:
    assert property (tx_sig_insert_now |->
                     $past(signaling_control.tx_hw_ins) &&
                     (!$past(signaling_control.tx_per_ch) || $past(tx_blk_s)))
    else $error("transmit insertion outside its enable");
  AST_IDLE_SPLIT:
    assert property (tx_idle_flag |=> tx_idle_code_now != tx_loopback_now)
    else $error("idle flag did not pick exactly one function");
  AST_REINSERT:
    assert property (rx_reinsert_now |-> ctrl.rx_reinsert)
    else $error("reinsertion active while disabled");
  AST_FORCE_ONES:
    assert property (ctrl.rx_force_ones == $past(signaling_control.force_ones))
    else $error("force ones level lags its bit");
  AST_CRC_SEL:
    assert property (ctrl.tx_japan_crc ==
                     $past(tx_crc_and_monitor_select.japan_crc))
    else $error("transmit CRC select not followed");
  AST_MON_CAPTURE:
    assert property (tx_chan_valid &&
                     tx_chan_num == tx_crc_and_monitor_select.mon_sel |=>
                     tx_channel_monitor_reg == $past(tx_chan_data))
    else $error("selected channel byte not captured");
endmodule // fsc_regs

/* File: fsc_regs_test.sv */
// Self-checking bench for the framer signaling control register bank
`timescale 1ns/1ps
`include "fsc_defines.svh"

module fsc_regs_test;
  import fsc_pkg::*;

  // Expected bus answer
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } fsc_exp_s;

  // -------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------
  logic          sys_clk;
  logic          nrst;
  logic [7:0]    address;
  logic          read;
  logic          write;
  logic [31:0]   writedata;
  logic [31:0]   readdata;
  logic [1:0]    response;
  logic          waitrequest;
  logic          rx_freeze_req;
  logic          rx_channel_block;
  logic          tx_channel_block_in;
  logic          tx_idle_flag;
  logic [4:0]    tx_chan_num;
  logic          tx_chan_valid;
  logic [7:0]    tx_chan_data;
  fsc_ctrl_out_s ctrl;
  logic          rx_reinsert_now;
  logic          tx_sig_insert_now;
  logic          tx_idle_code_now;
  logic          tx_loopback_now;
  logic [4:0]    rx_monitor_channel_sel;
  logic          rx_elastic_align;
  logic          tx_elastic_align;
  int            err_count;
  int            n_compared;
  fsc_exp_s      exp_q[$];
  logic [16:0]   ctrl_all;

  localparam logic [7:0] A_SIG = {`FSC_IDX_SIG_CTRL, 2'b00};
  localparam logic [7:0] A_TX  = {`FSC_IDX_TX_CRC_MON, 2'b00};
  localparam logic [7:0] A_RX  = {`FSC_IDX_RX_CRC_MON, 2'b00};
  localparam logic [7:0] A_MON = {`FSC_IDX_TX_MON_REG, 2'b00};

  fsc_regs u_dut (
    .sys_clk                (sys_clk),
    .nrst                   (nrst),
    .address                (address),
    .read                   (read),
    .write                  (write),
    .writedata              (writedata),
    .readdata               (readdata),
    .response               (response),
    .waitrequest            (waitrequest),
    .rx_freeze_req          (rx_freeze_req),
    .rx_channel_block       (rx_channel_block),
    .tx_channel_block_in    (tx_channel_block_in),
    .tx_idle_flag           (tx_idle_flag),
    .tx_chan_num            (tx_chan_num),
    .tx_chan_valid          (tx_chan_valid),
    .tx_chan_data           (tx_chan_data),
    .ctrl                   (ctrl),
    .rx_reinsert_now        (rx_reinsert_now),
    .tx_sig_insert_now      (tx_sig_insert_now),
    .tx_idle_code_now       (tx_idle_code_now),
    .tx_loopback_now        (tx_loopback_now),
    .rx_monitor_channel_sel (rx_monitor_channel_sel),
    .rx_elastic_align       (rx_elastic_align),
    .tx_elastic_align       (tx_elastic_align)
  );

  // All control levels in one vector
  assign ctrl_all = {ctrl, rx_reinsert_now, tx_sig_insert_now,
                     tx_idle_code_now, tx_loopback_now,
                     rx_monitor_channel_sel, rx_elastic_align,
                     tx_elastic_align};

  // -------------------------------------------------------------
  // Compare tasks, verdict and bus access
  // -------------------------------------------------------------
  task automatic check_read(input fsc_exp_s got, input fsc_exp_s exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_ctrl(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Request held until waitrequest is sampled low at a rising edge;
  // the write lands and read data is taken at that same edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) err_count++;
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r);
    exp_q.push_back('{data: {24'h0, d}, resp: r});
    bus(1'b0, a, 8'h00);
  endtask

  // Expected control levels from register values and pins
  function automatic logic [16:0] ctrl_exp(input logic [7:0] s,
      input logic [7:0] t, input logic [7:0] r, input logic [3:0] p);
    logic frz;
    frz = s[3] | (s[4] & p[3]);
    return {frz, frz & s[7], s[5], s[7], t[7], r[7],
            s[7] & (~s[6] | p[2]), s[2] & (~s[1] | p[1]),
            ~s[0] & p[0], s[0] & p[0], r[4:0], r[6], r[5]};
  endfunction

  // -------------------------------------------------------------
  // Clock, result watcher and watchdog
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Read answers taken at the edge that sees waitrequest low
  always @(posedge sys_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) err_count++;
      else check_read({readdata, response}, exp_q.pop_front());
    end
  end

  // Whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_of_test();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    logic [7:0] s, t, r;
    logic [3:0] p;
    logic [4:0] sel;
    logic [7:0] chd [0:23];
    {nrst, address, read, write, writedata} = '0;
    {rx_freeze_req, rx_channel_block, tx_channel_block_in} = '0;
    {tx_idle_flag, tx_chan_num, tx_chan_valid, tx_chan_data} = '0;
    err_count  = 0;
    n_compared = 0;
    void'($urandom(13290));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    check_ctrl(ctrl_all, 17'h0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    // Reset values and the byte-address map; raw index is unmapped
    for (int i = 0; i < 4; i++) rd(i == 0 ? A_SIG : i == 1 ? A_TX :
                                 i == 2 ? A_RX : A_MON, 8'h00,
                                 `FSC_RESP_OKAY);
    bus(1'b1, 8'h11, 8'hff);
    rd(8'h11, 8'h00, `FSC_RESP_SLVERR);
    rd(8'h48, 8'h00, `FSC_RESP_SLVERR);
    rd(A_SIG, 8'h00, `FSC_RESP_OKAY);
    // Random register contents and pin levels, then every control
    repeat (40) begin
      s = 8'($urandom);
      t = 8'($urandom) & `FSC_TX_CRC_WMASK;
      r = 8'($urandom);
      p = 4'($urandom);
      @(posedge sys_clk);
      {rx_freeze_req, rx_channel_block, tx_channel_block_in,
       tx_idle_flag} <= p;
      bus(1'b1, A_SIG, s);
      bus(1'b1, A_TX, t);
      bus(1'b1, A_RX, r);
      rd(A_SIG, s, `FSC_RESP_OKAY);
      rd(A_TX, t & `FSC_TX_CRC_WMASK, `FSC_RESP_OKAY);
      rd(A_RX, r, `FSC_RESP_OKAY);
      @(negedge sys_clk);
      check_ctrl(ctrl_all, ctrl_exp(s, t & `FSC_TX_CRC_WMASK, r,
                 p));
    end
    // Channel monitor: first, last and two random middle channels
    for (int k = 0; k < 4; k++) begin
      sel = k == 0 ? 5'h00 : k == 1 ? 5'h17 : 5'($urandom_range(22, 1));
      bus(1'b1, A_TX, {3'h0, sel});
      for (int i = 0; i < 24; i++) begin
        chd[i] = 8'($urandom);
        @(posedge sys_clk);
        tx_chan_num   <= 5'(i);
        tx_chan_data  <= chd[i];
        tx_chan_valid <= 1'b1;
      end
      // Selected channel again without valid must not capture
      @(posedge sys_clk);
      tx_chan_num   <= sel;
      tx_chan_data  <= ~chd[sel];
      tx_chan_valid <= 1'b0;
      bus(1'b1, A_MON, ~chd[sel]);
      rd(A_MON, chd[sel], `FSC_RESP_OKAY);
    end
    repeat (4) @(posedge sys_clk);
    if (exp_q.size() != 0) err_count++;
    end_of_test();
  end

endmodule // fsc_regs_test
